// *** common/lane_eq_pkg.sv ***
package lane_eq_pkg;
  localparam logic [7:0] lane_ctrl_addr = 8'h13;
  localparam logic [7:0] usb_eq_addr = 8'h20;
  localparam logic [7:0] lane_ctrl_reset = 8'h00;
  localparam logic [7:0] usb_eq_reset = 8'h00;
  localparam logic [7:0] lane_ctrl_writable = 8'hBF;
  localparam int snoop_off_bit = 7;
  localparam int reserved_bit = 6;
  localparam int route_ovr_lsb = 4;
  localparam int second_eq_lsb = 4;
  localparam int first_eq_lsb = 0;
  localparam logic [1:0] route_by_config = 2'h0;
  localparam logic [1:0] route_straight = 2'h1;
  localparam logic [1:0] route_crossed = 2'h2;
  localparam logic [1:0] route_open = 2'h3;
  localparam logic [1:0] cfg_all_off = 2'h0;
  localparam logic [1:0] cfg_usb_only = 2'h1;
  localparam logic [1:0] cfg_four_lanes = 2'h2;
  localparam logic [1:0] cfg_two_lanes_usb = 2'h3;
  localparam logic [4:0] lane_count_one = 5'h01;
  localparam logic [4:0] lane_count_two = 5'h02;
  localparam logic [4:0] lane_count_four = 5'h04;
  localparam logic [1:0] eq_strap_reset = 2'h0;
  typedef enum logic [1:0] {sb_open, sb_straight, sb_crossed} sideband_route_t;
endpackage : lane_eq_pkg

// *** common/lane_route_if.sv ***
`timescale 1ns/1ps
interface lane_route_if;
  logic [7:0] lane_ctrl;
  logic [1:0] lane_config_select;
  logic orientation_flip_select;
  logic [4:0] snooped_lane_count;
  logic [3:0] next_lane_on;
  lane_eq_pkg::sideband_route_t next_route;
  modport owner (
    output lane_ctrl,
    output lane_config_select,
    output orientation_flip_select,
    output snooped_lane_count,
    input next_lane_on,
    input next_route
  );
  modport decoder (
    input lane_ctrl,
    input lane_config_select,
    input orientation_flip_select,
    input snooped_lane_count,
    output next_lane_on,
    output next_route
  );
endinterface : lane_route_if

// *** core/dp_aux_sbu_lane_eq_ctrl.sv ***
`timescale 1ns/1ps
module dp_aux_sbu_lane_eq_ctrl (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] lane_config_select,
  input wire logic orientation_flip_select,
  input wire logic eq_from_registers,
  input wire logic [4:0] snooped_lane_count,
  input wire logic [1:0] usb_eq_strap_pins,
  output logic [3:0] lane_on,
  output logic auxn_to_sbu1,
  output logic auxp_to_sbu2,
  output logic auxn_to_sbu2,
  output logic auxp_to_sbu1,
  output logic [3:0] rx_first_eq_level,
  output logic [3:0] rx_second_eq_level
);
  logic [7:0] lane_ctrl;
  logic eq_wr;
  lane_route_if rt ();

  assign eq_wr = reg_wr && (reg_addr == lane_eq_pkg::usb_eq_addr);

  // reserved bit masked on write so it always reads zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      lane_ctrl <= lane_eq_pkg::lane_ctrl_reset;
    else if (reg_wr && reg_addr == lane_eq_pkg::lane_ctrl_addr)
      lane_ctrl <= reg_wdata & lane_eq_pkg::lane_ctrl_writable;
  end

  assign rt.lane_ctrl = lane_ctrl;
  assign rt.lane_config_select = lane_config_select;
  assign rt.orientation_flip_select = orientation_flip_select;
  assign rt.snooped_lane_count = snooped_lane_count;

  lane_route_decode u_decode (
    .rt(rt)
  );

  // controls registered: a write lands one cycle later
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lane_on <= 4'h0;
      auxn_to_sbu1 <= 1'b0;
      auxp_to_sbu2 <= 1'b0;
      auxn_to_sbu2 <= 1'b0;
      auxp_to_sbu1 <= 1'b0;
    end
    else
    begin
      lane_on <= rt.next_lane_on;
      auxn_to_sbu1 <= (rt.next_route == lane_eq_pkg::sb_straight);
      auxp_to_sbu2 <= (rt.next_route == lane_eq_pkg::sb_straight);
      auxn_to_sbu2 <= (rt.next_route == lane_eq_pkg::sb_crossed);
      auxp_to_sbu1 <= (rt.next_route == lane_eq_pkg::sb_crossed);
    end
  end

  eq_field #(
    .width(4)
  ) u_eq_first (
    .clk(clk),
    .rst_b(rst_b),
    .eq_from_registers(eq_from_registers),
    .usb_eq_strap_pins(usb_eq_strap_pins),
    .wr_en(eq_wr),
    .wr_data(reg_wdata[lane_eq_pkg::first_eq_lsb +: 4]),
    .level(rx_first_eq_level)
  );

  eq_field #(
    .width(4)
  ) u_eq_second (
    .clk(clk),
    .rst_b(rst_b),
    .eq_from_registers(eq_from_registers),
    .usb_eq_strap_pins(usb_eq_strap_pins),
    .wr_en(eq_wr),
    .wr_data(reg_wdata[lane_eq_pkg::second_eq_lsb +: 4]),
    .level(rx_second_eq_level)
  );

  // read data registered; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_addr == lane_eq_pkg::lane_ctrl_addr)
      reg_rdata <= lane_ctrl;
    else if (reg_addr == lane_eq_pkg::usb_eq_addr)
      reg_rdata <= {rx_second_eq_level, rx_first_eq_level};
    else
      reg_rdata <= 8'h00;
  end
endmodule : dp_aux_sbu_lane_eq_ctrl

// *** core/eq_field.sv ***
`timescale 1ns/1ps
module eq_field #(
  parameter int width = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic eq_from_registers,
  input wire logic [1:0] usb_eq_strap_pins,
  input wire logic wr_en,
  input wire logic [width-1:0] wr_data,
  output logic [width-1:0] level
);
  // strap code sits in the low bits, upper bits zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      level <= '0;
    else if (!eq_from_registers)
      level <= width'(usb_eq_strap_pins);
    else if (wr_en)
      level <= wr_data;
  end
endmodule : eq_field

// *** core/lane_route_decode.sv ***
`timescale 1ns/1ps
module lane_route_decode (
  lane_route_if.decoder rt
);
  logic snoop_off;
  logic [3:0] snoop_lanes;
  logic [3:0] cfg_lanes;
  logic [1:0] route_ovr;

  assign snoop_off = rt.lane_ctrl[lane_eq_pkg::snoop_off_bit];
  assign route_ovr = rt.lane_ctrl[lane_eq_pkg::route_ovr_lsb +: 2];

  // lanes the configuration select allows at all
  always_comb
  begin
    case (rt.lane_config_select)
      lane_eq_pkg::cfg_four_lanes: cfg_lanes = 4'hF;
      lane_eq_pkg::cfg_two_lanes_usb: cfg_lanes = 4'h3;
      default: cfg_lanes = 4'h0;
    endcase
  end

  // unused lanes dropped to save power
  always_comb
  begin
    case (rt.snooped_lane_count)
      lane_eq_pkg::lane_count_one: snoop_lanes = 4'h1;
      lane_eq_pkg::lane_count_two: snoop_lanes = 4'h3;
      lane_eq_pkg::lane_count_four: snoop_lanes = 4'hF;
      default: snoop_lanes = 4'h0;
    endcase
  end

  // disable bits are kept but ignored while snooping
  assign rt.next_lane_on = cfg_lanes &
      (snoop_off ? ~rt.lane_ctrl[3:0] : snoop_lanes);

  always_comb
  begin
    case (route_ovr)
      lane_eq_pkg::route_straight: rt.next_route = lane_eq_pkg::sb_straight;
      lane_eq_pkg::route_crossed: rt.next_route = lane_eq_pkg::sb_crossed;
      lane_eq_pkg::route_open: rt.next_route = lane_eq_pkg::sb_open;
      default:
      begin
        if (cfg_lanes == 4'h0)
          rt.next_route = lane_eq_pkg::sb_open;
        else if (rt.orientation_flip_select)
          rt.next_route = lane_eq_pkg::sb_crossed;
        else
          rt.next_route = lane_eq_pkg::sb_straight;
      end
    endcase
  end
endmodule : lane_route_decode

// *** sim/lane_eq_properties.sv ***
`timescale 1ns/1ps
module lane_eq_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] lane_config_select,
  input wire logic eq_from_registers,
  input wire logic [1:0] usb_eq_strap_pins,
  input wire logic [3:0] lane_on,
  input wire logic auxn_to_sbu1,
  input wire logic auxp_to_sbu2,
  input wire logic auxn_to_sbu2,
  input wire logic auxp_to_sbu1,
  input wire logic [3:0] rx_first_eq_level,
  input wire logic [3:0] rx_second_eq_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic [3:0] sb = {auxn_to_sbu1, auxp_to_sbu2, auxn_to_sbu2, auxp_to_sbu1};
  wire logic [3:0] off_bits = reg_wdata[3:0];
  wire logic ctl_wr = reg_wr && reg_addr == 8'h13;
  function automatic logic [3:0] cfg_mask(input logic [1:0] c);
    return c == 2'h2 ? 4'hF : (c == 2'h3 ? 4'h3 : 4'h0);
  endfunction : cfg_mask
  // config must hold while the write ripples through to the lane flops
  sequence manual_wr;
    ctl_wr && reg_wdata[7] ##1 $stable(lane_config_select);
  endsequence
  straight_route_a: assert property (ctl_wr && reg_wdata[5:4] == 2'h1 |-> ##2 sb == 4'hC)
    else $error("straight override not routed");
  crossed_route_a: assert property (ctl_wr && reg_wdata[5:4] == 2'h2 |-> ##2 sb == 4'h3)
    else $error("crossed override not routed");
  open_route_a: assert property (ctl_wr && reg_wdata[5:4] == 2'h3 |-> ##2 sb == 4'h0)
    else $error("open override still connected");
  lane_manual_a: assert property (manual_wr |=> lane_on ==
    (cfg_mask($past(lane_config_select)) & ~$past(off_bits, 2))) else $error("lane bits ignored");
  eq_strap_a: assert property (!eq_from_registers |=> {rx_second_eq_level, rx_first_eq_level}
    == {2'h0, $past(usb_eq_strap_pins), 2'h0, $past(usb_eq_strap_pins)}) else $error("eq not strap");
  eq_write_a: assert property (eq_from_registers && reg_wr && reg_addr == 8'h20 |=>
    {rx_second_eq_level, rx_first_eq_level} == $past(reg_wdata)) else $error("eq write lost");
  reserved_read_a: assert property (reg_addr == 8'h13 |=> !reg_rdata[6])
    else $error("reserved bit reads one");
  unmapped_read_a: assert property (reg_addr != 8'h13 && reg_addr != 8'h20 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : lane_eq_properties
bind dp_aux_sbu_lane_eq_ctrl lane_eq_properties lane_eq_properties_inst (.*);

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, eq_from_registers = 1'b0;
  logic orientation_flip_select = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0] lane_config_select = 2'h1, usb_eq_strap_pins = 2'h0;
  logic [4:0] snooped_lane_count = 5'h00;
  logic [3:0] lane_on, rx_first_eq_level, rx_second_eq_level;
  logic auxn_to_sbu1, auxp_to_sbu2, auxn_to_sbu2, auxp_to_sbu1;
  wire logic [7:0] sb = {4'h0, auxn_to_sbu1, auxp_to_sbu2, auxn_to_sbu2, auxp_to_sbu1};
  int fail_count = 0, n_compared = 0;
  dp_aux_sbu_lane_eq_ctrl dp_aux_sbu_lane_eq_ctrl_inst (.*);
  initial forever #5 clk = ~clk;
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // waits two edges so lane and route flops have settled before a check
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    chk(reg_rdata, exp);
  endtask : rd
  task t_route;
    chk({lane_on, sb[3:0]}, 8'h00);
    rd(8'h13, 8'h00);
    rd(8'h20, 8'h00);
    @(posedge clk);
    lane_config_select <= 2'h2;
    for (int v = 1; v < 4; v++)
    begin
      wr(8'h13, 8'h40 | 8'(v << 4));
      chk(sb, v == 1 ? 8'h0C : (v == 2 ? 8'h03 : 8'h00));
      rd(8'h13, 8'(v << 4));
    end
    wr(8'h13, 8'h00);
    chk(sb, 8'h0C);
    orientation_flip_select <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(sb, 8'h03);
    @(posedge clk);
    orientation_flip_select <= 1'b0;
    lane_config_select <= 2'h1;
    wr(8'h13, 8'h00);
    chk(sb, 8'h00);
    rd(8'h21, 8'h00);
    $display("route test done");
  endtask : t_route
  task t_lanes;
    @(posedge clk);
    lane_config_select <= 2'h2;
    snooped_lane_count <= 5'h02;
    wr(8'h13, 8'h0F);
    chk({4'h0, lane_on}, 8'h03);
    wr(8'h13, 8'h85);
    chk({4'h0, lane_on}, 8'h0A);
    @(posedge clk);
    lane_config_select <= 2'h3;
    repeat (2) @(posedge clk);
    #1;
    chk({4'h0, lane_on}, 8'h02);
    @(posedge clk);
    lane_config_select <= 2'h2;
    snooped_lane_count <= 5'h04;
    wr(8'h13, 8'h0F);
    chk({4'h0, lane_on}, 8'h0F);
    @(posedge clk);
    snooped_lane_count <= 5'h01;
    repeat (2) @(posedge clk);
    #1;
    chk({4'h0, lane_on}, 8'h01);
    @(posedge clk);
    snooped_lane_count <= 5'h03;
    repeat (2) @(posedge clk);
    #1;
    chk({4'h0, lane_on}, 8'h00);
    $display("lane test done");
  endtask : t_lanes
  task t_eq;
    @(posedge clk);
    usb_eq_strap_pins <= 2'h2;
    wr(8'h20, 8'h5A);
    chk({rx_second_eq_level, rx_first_eq_level}, 8'h22);
    @(posedge clk);
    eq_from_registers <= 1'b1;
    wr(8'h20, 8'h5A);
    chk({rx_second_eq_level, rx_first_eq_level}, 8'h5A);
    rd(8'h20, 8'h5A);
    $display("eq test done");
  endtask : t_eq
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    t_route;
    t_lanes;
    t_eq;
    end_sim;
  end
  // whole run needs well under 200 cycles
  initial
  begin
    #20000;
    fail_count++;
    end_sim;
  end
endmodule : testbench
